// [hw/ocd_regs.vh]
// Function
// (R1) comparator path maps low bit 0, high 1
// (R2) data path maps low bit -1, high +1
// (R3) comparator result is unsigned straight binary
// (R4) comparator latency is osr times order clocks
// (R5) filter order selectable as three, two, one
// (R6) step settles in about order output samples
// (R7) high crossing drives high warning output low
// (R8) low crossing drives low warning output low
// (R9) capture request forces both warnings low first
// (R10) data trigger crossing drives both warnings high
// (R11) software gives thresholds as full-scale percentages; the code takes the trigger threshold as a raw 16-bit data value
// (R12) trigger, high and low thresholds kept separately
// (R13) software selects channel one as trigger channel; the code has one data channel and no channel select
// (R14) short comparator ratio reacts before data path
// (R15) data result is 16-bit signed, clip to clip
// (R16) crossing is at-or-above high, at-or-below low
`ifndef OCD_REGS_VH
`define OCD_REGS_VH

`define ACC_W          26
`define OSR_W          9

`define OFF_CTRL       8'h00
`define OFF_CMP_OSR    8'h04
`define OFF_CMP_ORDER  8'h08
`define OFF_DAT_OSR    8'h0c
`define OFF_DAT_ORDER  8'h10
`define OFF_DAT_SHIFT  8'h14
`define OFF_HIGH_PCT   8'h18
`define OFF_LOW_PCT    8'h1c
`define OFF_TRIG       8'h20
`define OFF_DAT_RES    8'h24
`define OFF_CMP_RES    8'h28
`define OFF_STATUS     8'h2c
`define OFF_INT_CLR    8'h30
`define OFF_INT_EN     8'h34
`define OFF_STATE      8'h38

`define CTRL_ENABLE    0
`define CTRL_CAPTURE   1

`define EV_HIGH        0
`define EV_LOW         1
`define EV_TRIG        2
`define EV_DATA        3
`define EV_W           4

`define RST_CTRL       1'b0
`define RST_CMP_OSR    9'h008
`define RST_CMP_ORDER  2'h3
`define RST_DAT_OSR    9'h100
`define RST_DAT_ORDER  2'h3
`define RST_DAT_SHIFT  5'h09
`define RST_HIGH_PCT   7'h64
`define RST_LOW_PCT    7'h00
`define RST_TRIG       16'h0000
`define PCT_FULL       7'h64

`endif

// [hw/pin_sync.v]
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter W = 2
) (
    // clock and reset
    input  wire         mclk,
    input  wire         resetn,
    // pins in, synchronised out
    input  wire [W-1:0] pin_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] meta_q;

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_q   <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta_q   <= pin_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// [hw/sinc_filter.v]
`timescale 1ns/100ps
`default_nettype none
`include "ocd_regs.vh"
module sinc_filter #(
    parameter W       = 26,
    parameter OW      = 9,
    parameter BIPOLAR = 0
) (
    // clock and reset
    input  wire                mclk,
    input  wire                resetn,
    // control
    input  wire                enable,
    input  wire [OW-1:0]       osr,
    input  wire [1:0]          order,
    // modulator bit stream
    input  wire                bit_in,
    input  wire                bit_valid,
    // decimated result
    output reg  signed [W-1:0] result,
    output reg                 result_valid
);
    wire signed [W-1:0] one_v  = {{(W-1){1'b0}}, 1'b1};
    wire signed [W-1:0] low_v  = BIPOLAR ? {W{1'b1}} : {W{1'b0}};
    wire signed [W-1:0] x_v    = bit_in ? one_v : low_v;
    wire [OW-1:0]       osr_m1 = (osr == {OW{1'b0}}) ? {OW{1'b0}} : osr - 1'b1;
    wire [1:0]          ord_ix = (order == 2'h0) ? 2'h0 : order - 2'h1;

    reg  signed [W-1:0] integ_q [0:2];
    reg  signed [W-1:0] prev_q  [0:2];
    wire signed [W-1:0] comb_in [0:3];
    reg  [OW-1:0]       cnt_q;
    reg                 dec_q;

    assign comb_in[0] = integ_q[ord_ix];

    genvar k;
    generate
        for (k = 0; k < 3; k = k + 1) begin : stage
            wire signed [W-1:0] feed;
            if (k == 0) begin : first
                assign feed = x_v;
            end else begin : chain
                assign feed = integ_q[k-1];
            end
            // one comb per order; settles in about order samples
            assign comb_in[k+1] = comb_in[k] - prev_q[k]; // (R6)
            always @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    integ_q[k] <= {W{1'b0}};
                    prev_q[k]  <= {W{1'b0}};
                end else if (!enable) begin
                    integ_q[k] <= {W{1'b0}};
                    prev_q[k]  <= {W{1'b0}};
                end else begin
                    if (bit_valid)
                        integ_q[k] <= integ_q[k] + feed;
                    if (dec_q)
                        prev_q[k] <= comb_in[k];
                end
            end
        end
    endgenerate

    // decimate by osr; order integrators plus order combs (sinc^order)
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_q        <= {OW{1'b0}};
            dec_q        <= 1'b0;
            result       <= {W{1'b0}};
            result_valid <= 1'b0;
        end else begin
            dec_q        <= 1'b0;
            result_valid <= 1'b0;
            if (!enable) begin
                cnt_q <= {OW{1'b0}};
            end else begin
                if (bit_valid) begin
                    if (cnt_q >= osr_m1) begin // (R4)
                        cnt_q <= {OW{1'b0}};
                        dec_q <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                if (dec_q) begin
                    result       <= comb_in[ord_ix + 2'h1]; // (R5)
                    result_valid <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [hw/overcurrent_comparator.v]
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "ocd_regs.vh"
module overcurrent_comparator (
    // clock and reset
    input  wire        mclk,
    input  wire        resetn,
    // modulator pins
    input  wire        mod_clk_pin,
    input  wire        mod_data_pin,
    // register port
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [31:0] rdata,
    // warnings and interrupt
    output reg         high_warn_n,
    output reg         low_warn_n,
    output reg         irq
);
    localparam W  = `ACC_W;
    localparam OW = `OSR_W;

    // pin sampling
    wire [1:0] pins_s;
    reg        mclk_prev_q;
    wire       mod_clk_s  = pins_s[0];
    wire       mod_data_s = pins_s[1];
    wire       bit_tick   = mod_clk_s & ~mclk_prev_q;

    pin_sync #(
        .W(2)
    ) u_sync (
        .mclk    (mclk),
        .resetn  (resetn),
        .pin_in  ({mod_data_pin, mod_clk_pin}),
        .sync_out(pins_s)
    );

    always @(posedge mclk or negedge resetn) begin
        if (!resetn)
            mclk_prev_q <= 1'b0;
        else
            mclk_prev_q <= mod_clk_s;
    end

    // configuration registers
    reg                 enable_q;
    reg  [OW-1:0]       cmp_osr_q;
    reg  [1:0]          cmp_order_q;
    reg  [OW-1:0]       dat_osr_q;
    reg  [1:0]          dat_order_q;
    reg  [4:0]          dat_shift_q;
    reg  [6:0]          high_pct_q;
    reg  [6:0]          low_pct_q;
    reg  signed [15:0]  trig_q;
    reg  [`EV_W-1:0]    int_en_q;
    reg  [`EV_W-1:0]    status_q;
    reg  [`EV_W-1:0]    status_d;

    wire wr_ctrl = wr && (addr == `OFF_CTRL);
    wire capture = wr_ctrl && wdata[`CTRL_CAPTURE];
    wire [`EV_W-1:0] clr_v = (wr && (addr == `OFF_INT_CLR)) ? wdata[`EV_W-1:0] : {`EV_W{1'b0}};

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            enable_q    <= `RST_CTRL;
            cmp_osr_q   <= `RST_CMP_OSR;
            cmp_order_q <= `RST_CMP_ORDER;
            dat_osr_q   <= `RST_DAT_OSR;
            dat_order_q <= `RST_DAT_ORDER;
            dat_shift_q <= `RST_DAT_SHIFT;
            high_pct_q  <= `RST_HIGH_PCT;
            low_pct_q   <= `RST_LOW_PCT;
            trig_q      <= `RST_TRIG;
            int_en_q    <= {`EV_W{1'b0}};
        end else if (wr) begin
            case (addr)
                `OFF_CTRL:      enable_q    <= wdata[`CTRL_ENABLE];
                `OFF_CMP_OSR:   cmp_osr_q   <= wdata[OW-1:0];
                `OFF_CMP_ORDER: cmp_order_q <= wdata[1:0];
                `OFF_DAT_OSR:   dat_osr_q   <= wdata[OW-1:0];
                `OFF_DAT_ORDER: dat_order_q <= wdata[1:0];
                `OFF_DAT_SHIFT: dat_shift_q <= wdata[4:0];
                `OFF_HIGH_PCT:  high_pct_q  <= wdata[6:0]; // (R12)
                `OFF_LOW_PCT:   low_pct_q   <= wdata[6:0]; // (R12)
                `OFF_TRIG:      trig_q      <= wdata[15:0]; // (R12)
                `OFF_INT_EN:    int_en_q    <= wdata[`EV_W-1:0];
                default: ;
            endcase
        end
    end

    // the two filter paths
    wire signed [W-1:0] cmp_res;
    wire                cmp_valid;
    wire signed [W-1:0] dat_res;
    wire                dat_valid;

    // unipolar accumulation (R1)
    sinc_filter #(
        .W      (W),
        .OW     (OW),
        .BIPOLAR(0)
    ) u_cmp (
        .mclk        (mclk),
        .resetn      (resetn),
        .enable      (enable_q),
        .osr         (cmp_osr_q),
        .order       (cmp_order_q),
        .bit_in      (mod_data_s),
        .bit_valid   (bit_tick),
        .result      (cmp_res),
        .result_valid(cmp_valid)
    );

    // bipolar accumulation (R2)
    sinc_filter #(
        .W      (W),
        .OW     (OW),
        .BIPOLAR(1)
    ) u_dat (
        .mclk        (mclk),
        .resetn      (resetn),
        .enable      (enable_q),
        .osr         (dat_osr_q),
        .order       (dat_order_q),
        .bit_in      (mod_data_s),
        .bit_valid   (bit_tick),
        .result      (dat_res),
        .result_valid(dat_valid)
    );

    // comparator full scale osr^order
    wire [W-1:0]  cmp_u = cmp_res; // (R3)
    wire [OW-1:0] cosr  = (cmp_osr_q == {OW{1'b0}}) ? {{(OW-1){1'b0}}, 1'b1} : cmp_osr_q;
    wire [17:0]   fs2   = cosr * cosr;
    wire [26:0]   fs3   = fs2 * cosr;
    reg  [31:0]   fs;

    always @* begin
        case (cmp_order_q)
            2'h2:    fs = {14'h0000, fs2};
            2'h3:    fs = {5'h00, fs3};
            default: fs = {23'h000000, cosr};
        endcase
    end

    wire [39:0] cmp_x100 = {14'h0000, cmp_u} * {33'h0, `PCT_FULL};
    wire [39:0] high_lim = {33'h0, high_pct_q} * {8'h00, fs};
    wire [39:0] low_lim  = {33'h0, low_pct_q} * {8'h00, fs};
    wire        high_hit = cmp_valid && (cmp_x100 >= high_lim); // (R16)
    wire        low_hit  = cmp_valid && (cmp_x100 <= low_lim); // (R16)

    // data result scaled and clipped to 16 bits
    wire signed [W-1:0] dsh    = dat_res >>> dat_shift_q;
    wire signed [W-1:0] dmax   = {{(W-16){1'b0}}, 16'h7fff};
    wire signed [W-1:0] dmin   = {{(W-16){1'b1}}, 16'h8000};
    wire signed [15:0]  dat16  = (dsh > dmax) ? 16'sh7fff :
                                 (dsh < dmin) ? 16'sh8000 : dsh[15:0]; // (R15)
    reg  signed [15:0]  dat16_q;
    reg  [W-1:0]        cmp_u_q;
    reg                 dat_below_q;
    reg                 waiting_q;
    reg                 armed_q;

    wire trig_hit = dat_valid && waiting_q && dat_below_q && (dat16 >= trig_q);

    // warning sequencing
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            high_warn_n <= 1'b1;
            low_warn_n  <= 1'b1;
            waiting_q   <= 1'b0;
            armed_q     <= 1'b0;
            dat_below_q <= 1'b0;
            dat16_q     <= 16'h0000;
            cmp_u_q     <= {W{1'b0}};
        end else begin
            if (dat_valid) begin
                dat16_q     <= dat16;
                dat_below_q <= (dat16 < trig_q);
            end
            if (cmp_valid)
                cmp_u_q <= cmp_u;
            if (capture) begin
                high_warn_n <= 1'b0; // (R9)
                low_warn_n  <= 1'b0; // (R9)
                waiting_q   <= 1'b1;
                armed_q     <= 1'b0;
                dat_below_q <= 1'b0;
            end else if (trig_hit) begin
                high_warn_n <= 1'b1; // (R10)
                low_warn_n  <= 1'b1; // (R10)
                waiting_q   <= 1'b0;
                armed_q     <= 1'b1;
            end else if (armed_q) begin
                if (high_hit)
                    high_warn_n <= 1'b0; // (R7) (R14)
                if (low_hit)
                    low_warn_n <= 1'b0; // (R8)
            end
        end
    end

    // sticky events, set beats clear
    always @* begin
        status_d = (status_q & ~clr_v) |
                   {dat_valid, trig_hit, low_hit, high_hit};
    end

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            status_q <= {`EV_W{1'b0}};
            irq      <= 1'b0;
        end else begin
            status_q <= status_d;
            irq      <= |(status_d & int_en_q);
        end
    end

    // read port
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            case (addr)
                `OFF_CTRL:      rdata <= {31'h0, enable_q};
                `OFF_CMP_OSR:   rdata <= {23'h0, cmp_osr_q};
                `OFF_CMP_ORDER: rdata <= {30'h0, cmp_order_q};
                `OFF_DAT_OSR:   rdata <= {23'h0, dat_osr_q};
                `OFF_DAT_ORDER: rdata <= {30'h0, dat_order_q};
                `OFF_DAT_SHIFT: rdata <= {27'h0, dat_shift_q};
                `OFF_HIGH_PCT:  rdata <= {25'h0, high_pct_q};
                `OFF_LOW_PCT:   rdata <= {25'h0, low_pct_q};
                `OFF_TRIG:      rdata <= {16'h0, trig_q};
                `OFF_DAT_RES:   rdata <= {{16{dat16_q[15]}}, dat16_q};
                `OFF_CMP_RES:   rdata <= {6'h00, cmp_u_q};
                `OFF_STATUS:    rdata <= {28'h0, status_q};
                `OFF_INT_EN:    rdata <= {28'h0, int_en_q};
                `OFF_STATE:     rdata <= {28'h0, armed_q, waiting_q, low_warn_n, high_warn_n};
                default:        rdata <= 32'h00000000;
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// [test/sd_modulator.sv]
`timescale 1ns/100ps
`default_nettype none
module sd_modulator (
    // clock from the controller side
    input  wire logic       mclk,
    // ones density out of 256, 256 gives all ones
    input  wire logic [8:0] density,
    // modulator pins
    output logic            mod_clk,
    output logic            mod_data
);
    logic [1:0] div_q;
    logic [7:0] acc_q;
    logic [8:0] sum;
    assign sum = {1'b0, acc_q} + density;
    initial begin
        div_q = 2'h0;
        acc_q = 8'h00;
        mod_clk = 1'b0;
        mod_data = 1'b0;
    end
    // bit period 8 mclk, new bit after falling edge
    always @(posedge mclk) begin
        div_q <= div_q + 2'h1;
        if (div_q == 2'h3) begin
            mod_clk <= ~mod_clk;
            if (mod_clk) begin
                mod_data <= sum[8];
                acc_q <= sum[7:0];
            end
        end
    end
endmodule
`default_nettype wire

// [test/ocd_checker_sva.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ocd_regs.vh"
module ocd_checker (
    // clock and reset
    input wire logic        mclk,
    input wire logic        resetn,
    // register port
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    // warnings and interrupt
    input wire logic        high_warn_n,
    input wire logic        low_warn_n,
    input wire logic        irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    wire cap = wr && addr == `OFF_CTRL && wdata[`CTRL_CAPTURE];
    wire en0 = wr && addr == `OFF_INT_EN;
    property p_cap_low; cap |=> !high_warn_n && !low_warn_n; endproperty
    a_cap_low: assert property (p_cap_low) else $error("warnings not low after capture");
    property p_arm; $rose(high_warn_n) |-> $rose(low_warn_n); endproperty
    a_arm: assert property (p_arm) else $error("warnings not armed together");
    property p_high; $fell(high_warn_n) && !$past(cap) |-> $stable(low_warn_n); endproperty
    a_high: assert property (p_high) else $error("high warning moved low warning");
    property p_low; $fell(low_warn_n) && !$past(cap) |-> $stable(high_warn_n); endproperty
    a_low: assert property (p_low) else $error("low warning moved high warning");
    property p_cmp; rd && addr == `OFF_CMP_RES |=> !rdata[31]; endproperty
    a_cmp: assert property (p_cmp) else $error("comparator result negative");
    property p_dat; rd && addr == `OFF_DAT_RES |=> rdata[31:15] inside {17'h0, 17'h1ffff}; endproperty
    a_dat: assert property (p_dat) else $error("data result not 16-bit signed");
    property p_idle; !rd |=> rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside read cycle");
    property p_unmap; rd && addr > `OFF_STATE |=> rdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_mask; en0 && wdata[3:0] == 4'h0 ##1 !en0 |=> !irq; endproperty
    a_mask: assert property (p_mask) else $error("masked interrupt still high");
endmodule
`default_nettype wire

// [test/tb_overcurrent_comparator.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ocd_regs.vh"
module tb_overcurrent_comparator;
    typedef struct {
        logic [1:0]  ord;
        logic [8:0]  dens;
        logic [31:0] cmp;
        logic [31:0] dat;
    } row_t;
    // comparator order, ones density, comparator and data results
    row_t        rows [6] = '{
        '{2'h1, 9'h100, 32'h8, 32'h4}, '{2'h1, 9'h000, 32'h0, 32'hfffffffc},
        '{2'h2, 9'h100, 32'h40, 32'h4}, '{2'h2, 9'h080, 32'h20, 32'h0},
        '{2'h3, 9'h100, 32'h200, 32'h4}, '{2'h3, 9'h000, 32'h0, 32'hfffffffc}};
    logic [7:0]  ra [13] = '{`OFF_CTRL, `OFF_CMP_OSR, `OFF_CMP_ORDER, `OFF_DAT_OSR,
        `OFF_DAT_ORDER, `OFF_DAT_SHIFT, `OFF_HIGH_PCT, `OFF_LOW_PCT, `OFF_TRIG,
        `OFF_STATUS, `OFF_STATE, `OFF_CMP_RES, 8'h3c};
    logic [31:0] rv [13] = '{32'h0, 32'h8, 32'h3, 32'h100, 32'h3, 32'h9, 32'h64,
        32'h0, 32'h0, 32'h0, 32'h3, 32'h0, 32'h0};
    logic        mclk, resetn, wr, rd, mod_clk_pin, mod_data_pin;
    logic        high_warn_n, low_warn_n, irq;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    logic [8:0]  density;
    int          fail_count, total_checks, i, r;
    overcurrent_comparator u_overcurrent_comparator (.mclk(mclk), .resetn(resetn),
        .mod_clk_pin(mod_clk_pin), .mod_data_pin(mod_data_pin), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .high_warn_n(high_warn_n),
        .low_warn_n(low_warn_n), .irq(irq));
    sd_modulator u_sd_modulator (.mclk(mclk), .density(density), .mod_clk(mod_clk_pin),
        .mod_data(mod_data_pin));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic end_sim;
        if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(nm, e, rdata);
    endtask
    // high warning, low warning, interrupt
    task automatic pins(input logic [2:0] e);
        #1 chk("pins", {29'h0, e}, {29'h0, high_warn_n, low_warn_n, irq});
    endtask
    task automatic wait_pin(input logic hw, input logic e);
        for (i = 0; i < 3000 && (hw ? high_warn_n : low_warn_n) !== e; i++) @(posedge mclk);
        repeat (3) @(posedge mclk);
    endtask
    initial begin
        repeat (30000) @(posedge mclk);
        fail_count++;
        end_sim();
    end
    initial begin
        resetn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        density = 9'h000;
        fail_count = 0;
        total_checks = 0;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        wr_reg(`OFF_DAT_OSR, 32'h4);
        wr_reg(`OFF_DAT_ORDER, 32'h1);
        wr_reg(`OFF_DAT_SHIFT, 32'h0);
        for (r = 0; r < 6; r++) begin
            density <= rows[r].dens;
            wr_reg(`OFF_CTRL, 32'h0);
            wr_reg(`OFF_CMP_ORDER, {30'h0, rows[r].ord});
            wr_reg(`OFF_CTRL, 32'h1);
            repeat (rows[r].ord * 64 + 80) @(posedge mclk);
            rd_chk("cmp_res", `OFF_CMP_RES, rows[r].cmp);
            rd_chk("dat_res", `OFF_DAT_RES, rows[r].dat);
        end
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        pins(3'b110);
        wr_reg(`OFF_CMP_RES, 32'hffff);
        wr_reg(8'h3c, 32'hffff);
        for (r = 0; r < 13; r++) rd_chk("reg", ra[r], rv[r]);
        wr_reg(`OFF_DAT_OSR, 32'h40);
        wr_reg(`OFF_DAT_ORDER, 32'h1);
        wr_reg(`OFF_DAT_SHIFT, 32'h0);
        wr_reg(`OFF_HIGH_PCT, 32'h5e);
        wr_reg(`OFF_LOW_PCT, 32'h6);
        wr_reg(`OFF_INT_EN, 32'h1);
        wr_reg(`OFF_CTRL, 32'h3);
        pins(3'b000);
        repeat (1200) @(posedge mclk);
        pins(3'b000);
        rd_chk("status", `OFF_STATUS, 32'ha);
        density <= 9'h080;
        wait_pin(1'b1, 1'b1);
        pins(3'b110);
        density <= 9'h100;
        wait_pin(1'b1, 1'b0);
        pins(3'b011);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= `OFF_DAT_RES;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk("dat_lag", 32'h1, {31'h0, rdata < 32'h40});
        density <= 9'h080;
        repeat (300) @(posedge mclk);
        wr_reg(`OFF_INT_CLR, 32'hf);
        repeat (2) @(posedge mclk);
        pins(3'b010);
        wr_reg(`OFF_CTRL, 32'h3);
        pins(3'b000);
        density <= 9'h000;
        repeat (1200) @(posedge mclk);
        density <= 9'h080;
        wait_pin(1'b1, 1'b1);
        pins(3'b110);
        wr_reg(`OFF_INT_CLR, 32'hf);
        wr_reg(`OFF_INT_EN, 32'h2);
        density <= 9'h000;
        wait_pin(1'b0, 1'b0);
        pins(3'b101);
        wr_reg(`OFF_INT_EN, 32'h0);
        repeat (2) @(posedge mclk);
        pins(3'b100);
        end_sim();
    end
endmodule
bind overcurrent_comparator ocd_checker u_ocd_checker (.mclk(mclk), .resetn(resetn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .high_warn_n(high_warn_n), .low_warn_n(low_warn_n), .irq(irq));
`default_nettype wire
